// File: common/rsis_consts.svh
// Constants of the receive status block: offsets, bit positions, resets.
// Assumes inclusion by bare name from the package and the design files.
`ifndef RSIS_CONSTS_SVH
`define RSIS_CONSTS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RSIS_OFS_STATUS  6'h08
`define RSIS_OFS_DATA_A  6'h09
`define RSIS_OFS_DATA_B  6'h0b

// ------------------------------------------------------------
// Reset values and field positions
// ------------------------------------------------------------
`define RSIS_STATUS_RST  8'h00
`define RSIS_CHAN_W      4
`define RSIS_BIT_FULL    0
`define RSIS_BIT_EOF     1
`define RSIS_BIT_FLOW    2
`define RSIS_BIT_VALID   3
`define RSIS_EN_FULL     0
`define RSIS_EN_EOF      1
`define RSIS_EN_OVER     2
`define RSIS_EN_UNDER    3

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RSIS_EOF_LEN_W   4

`endif

// File: common/rsis_pkg.sv
// Types shared by the receive status block and its channel slices.
// Assumes rsis_consts.svh is on the include path.
`include "rsis_consts.svh"

package rsis_pkg;

    // Events from one channel receiver, same clock domain
    typedef struct packed {
        logic load;       // Byte moved into the data register
        logic all_valid;  // Every bit of that byte is valid
        logic bit_tick;   // One bit time has passed
        logic bit_valid;  // The bit of this bit time was valid
    } rsis_rx_ev_t;

    // Status nibble of one channel, msb first as in the register
    typedef struct packed {
        logic valid;
        logic flow;
        logic eof;
        logic full;
    } rsis_stat_t;

endpackage

// File: src/rsis_chan.sv
// One receive channel's status slice: full, end of frame, flow
// violation and all-bits-valid, with its end-of-frame bit counter.
// Assumes all event inputs come from logic on core_clk.
`timescale 1ns/1ps
`include "rsis_consts.svh"

module rsis_chan #(
    parameter int LEN_W = `RSIS_EOF_LEN_W
) (
    input  wire logic               core_clk,  // 125 MHz clock
    input  wire logic               rstn,      // Sync reset, low
    input  wire logic               rx_en,     // Receive mode on
    input  wire rsis_pkg::rsis_rx_ev_t ev,     // Receiver events
    input  wire logic [LEN_W-1:0]   eof_len,   // End-of-frame length
    input  wire logic               data_rd,   // Host read data reg
    input  wire logic               stat_rd,   // Host read status
    input  wire logic [3:0]         irq_en,    // {under,over,eof,full}
    output rsis_pkg::rsis_stat_t    stat,      // Status nibble
    output logic                    irq,       // Enabled pending event
    output logic                    eof_pulse  // End of frame seen
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic             full_q, full_d;
    logic             eof_q, eof_d;
    logic             over_q, over_d;
    logic             under_q, under_d;
    logic             valid_q, valid_d;
    logic             unread_q, unread_d;
    logic             started_q, started_d;
    logic [LEN_W-1:0] cnt_q, cnt_d;
    logic             eof_ev;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        eof_ev    = 1'b0;
        started_d = started_q;
        cnt_d     = cnt_q;
        if (ev.bit_tick)
        begin
            if (ev.bit_valid)
            begin
                started_d = 1'b1;
                cnt_d     = '0;
            end
            else if (started_q)
            begin
                // Invalid bits must exceed the length; zero fires at once
                if (cnt_q >= eof_len)
                begin
                    eof_ev    = 1'b1;
                    started_d = 1'b0;
                    cnt_d     = '0;
                end
                else
                begin
                    cnt_d = cnt_q + LEN_W'(1);
                end
            end
        end
        // Set wins over the read clear so no event is lost
        full_d   = ev.load | (full_q & ~(data_rd | stat_rd));
        eof_d    = eof_ev | (eof_q & ~stat_rd);
        over_d   = (ev.load & unread_q & ~data_rd)
                   | (over_q & ~stat_rd);
        under_d  = (data_rd & ~unread_q) | (under_q & ~stat_rd);
        unread_d = ev.load | (unread_q & ~data_rd);
        valid_d  = ev.load ? ev.all_valid : valid_q;
        if (!rx_en)
        begin
            // Receive off: everything reads zero and framing restarts
            full_d    = 1'b0;
            eof_d     = 1'b0;
            over_d    = 1'b0;
            under_d   = 1'b0;
            valid_d   = 1'b0;
            unread_d  = 1'b0;
            started_d = 1'b0;
            cnt_d     = '0;
            eof_ev    = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            full_q    <= 1'b0;
            eof_q     <= 1'b0;
            over_q    <= 1'b0;
            under_q   <= 1'b0;
            valid_q   <= 1'b0;
            unread_q  <= 1'b0;
            started_q <= 1'b0;
            cnt_q     <= '0;
        end
        else
        begin
            full_q    <= full_d;
            eof_q     <= eof_d;
            over_q    <= over_d;
            under_q   <= under_d;
            valid_q   <= valid_d;
            unread_q  <= unread_d;
            started_q <= started_d;
            cnt_q     <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bits are kept whatever the enables say; enables only gate irq
    // A clear valid sends the host to the per-bit mask kept elsewhere
    assign stat.valid = valid_q;
    assign stat.flow  = over_q | under_q;
    assign stat.eof   = eof_q;
    assign stat.full  = full_q;
    assign eof_pulse  = eof_ev;

    // Valid never reaches the request line
    assign irq = (full_q  & irq_en[`RSIS_EN_FULL])
               | (eof_q   & irq_en[`RSIS_EN_EOF])
               | (over_q  & irq_en[`RSIS_EN_OVER])
               | (under_q & irq_en[`RSIS_EN_UNDER]);

endmodule

// File: src/rsis_top.sv
// Receive status register of a two-channel radio baseband.
// Assumes a register access port from the serial interface decoder and
// receiver event strobes, all on core_clk.
`timescale 1ns/1ps
`include "rsis_consts.svh"

module rsis_top #(
    parameter int LEN_W = `RSIS_EOF_LEN_W
) (
    input  wire logic                   core_clk,  // 125 MHz clock
    input  wire logic                   rstn,      // Sync reset, low
    input  wire logic [5:0]             reg_addr,  // Register offset
    input  wire logic                   reg_rd,    // Read strobe
    input  wire logic                   reg_wr,    // Write strobe
    input  wire logic [7:0]             reg_wdata, // Write data
    output logic      [7:0]             reg_rdata, // Read data
    output logic                        reg_hit,   // Read was mapped
    input  wire logic                   rx_en,     // Control bit 7
    input  wire logic [LEN_W-1:0]       eof_len,   // End-of-frame len
    input  wire logic [7:0]             irq_en,    // Rx enable register
    input  wire rsis_pkg::rsis_rx_ev_t  ev_a,      // Channel A events
    input  wire rsis_pkg::rsis_rx_ev_t  ev_b,      // Channel B events
    output logic [1:0]                  eof_pulse, // {B,A} frame end
    output logic                        irq        // Interrupt request
);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic                 stat_rd;
    logic [1:0]           data_rd;
    logic [1:0]           chan_irq;
    rsis_pkg::rsis_stat_t stat [2];
    rsis_pkg::rsis_rx_ev_t ev  [2];
    logic [7:0]           status;
    logic [7:0]           rdata_q, rdata_d;
    logic                 hit_q, hit_d;

    assign stat_rd    = reg_rd & (reg_addr == `RSIS_OFS_STATUS);
    assign data_rd[0] = reg_rd & (reg_addr == `RSIS_OFS_DATA_A);
    assign data_rd[1] = reg_rd & (reg_addr == `RSIS_OFS_DATA_B);
    assign ev[0]      = ev_a;
    assign ev[1]      = ev_b;

    // ------------------------------------------------------------
    // Channels: index 0 is A in the low nibble, 1 is B in the high
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++)
    begin : g_chan
        rsis_chan #(
            .LEN_W (LEN_W)
        ) u_chan (
            .core_clk  (core_clk),
            .rstn      (rstn),
            .rx_en     (rx_en),
            .ev        (ev[c]),
            .eof_len   (eof_len),
            .data_rd   (data_rd[c]),
            .stat_rd   (stat_rd),
            .irq_en    (irq_en[4*c +: 4]),
            .stat      (stat[c]),
            .irq       (chan_irq[c]),
            .eof_pulse (eof_pulse[c])
        );
    end

    // Channel B is the high nibble; bits 7..4 mirror 3..0.
    // Gated by rx_en so a read in the first cycle with receive off is zero
    // even before the channel state has been cleared.
    assign status = rx_en ? {stat[1], stat[0]}
                          : 8'h00;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Status is captured in the read cycle, before its clear lands.
    // Writes are accepted and dropped: the register is read-only.
    always_comb
    begin
        rdata_d = rdata_q;
        hit_d   = 1'b0;
        if (reg_rd)
        begin
            hit_d   = stat_rd;
            rdata_d = stat_rd ? status : 8'h00;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            rdata_q <= `RSIS_STATUS_RST;
            hit_q   <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            hit_q   <= hit_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_hit   = hit_q;
    assign irq       = rx_en & (|chan_irq);

endmodule

// File: tb/rsis_host.sv
// Host model: register reads and writes on the register port.
// Assumes the answer is registered on the same edge that samples the read.
`timescale 1ns/1ps
module rsis_host (
    input  wire logic       core_clk,  // Clock
    input  wire logic [7:0] reg_rdata, // Read data
    input  wire logic       reg_hit,   // Read was mapped
    output logic      [5:0] reg_addr,  // Offset
    output logic            reg_rd,    // Read strobe
    output logic            reg_wr,    // Write strobe
    output logic      [7:0] reg_wdata  // Write data
);
    initial
    begin
        reg_addr = 6'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // Strobe holds one full cycle; answer taken half a cycle later
    task automatic rd(input logic [5:0] a, output logic [7:0] d,
                      output logic h);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        h = reg_hit;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
endmodule

// File: tb/rsis_top_properties.sv
// Checker for the receive status block, bound to rsis_top.
// Assumes register port and receiver strobes all run on core_clk.
`timescale 1ns/1ps
module rsis_top_properties #(
    parameter int LEN_W = 4
) (
    input wire logic                  core_clk,  // Clock
    input wire logic                  rstn,      // Sync reset, low
    input wire logic [5:0]            reg_addr,  // Register offset
    input wire logic                  reg_rd,    // Read strobe
    input wire logic [7:0]            reg_rdata, // Read data
    input wire logic                  reg_hit,   // Read was mapped
    input wire logic                  rx_en,     // Receive mode
    input wire logic [LEN_W-1:0]      eof_len,   // Frame end length
    input wire logic [7:0]            irq_en,    // Enables
    input wire rsis_pkg::rsis_rx_ev_t ev_a,      // Channel A events
    input wire rsis_pkg::rsis_rx_ev_t ev_b,      // Channel B events
    input wire logic [1:0]            eof_pulse, // Frame end seen
    input wire logic                  irq        // Interrupt request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // Read port, receive off, requests, and frame end on channel A with zero length
    // ------------------------------------------------------------
    sequence s_tick_ok;
        rx_en && ev_a.bit_tick && ev_a.bit_valid;
    endsequence
    sequence s_tick_bad;
        rx_en && eof_len == '0 && ev_a.bit_tick && !ev_a.bit_valid;
    endsequence
    a_rdata_hold:
        assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_hit_status:
        assert property (reg_rd && reg_addr == 6'h08 |=> reg_hit)
        else $error("status read not flagged as mapped");
    a_miss_zero:
        assert property (reg_rd && reg_addr != 6'h08
                         |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    a_rxoff_read:
        assert property (!rx_en && reg_rd |=> reg_rdata == 8'h00)
        else $error("status nonzero with receive off");
    a_rxoff_irq:
        assert property (!rx_en |-> !irq)
        else $error("request with receive off");
    a_irq_noen:
        assert property (irq_en == 8'h00 |-> !irq)
        else $error("request with all enables off");
    a_eof_zero:
        assert property (s_tick_ok ##1 s_tick_bad |-> eof_pulse[0])
        else $error("no frame end at first invalid bit");
    a_full_irq:
        assert property (rx_en && ev_a.load && irq_en[0]
                         ##1 rx_en && irq_en[0] |-> irq)
        else $error("full A did not request");
    a_eof_irq:
        assert property (rx_en && eof_pulse[1] && irq_en[5]
                         ##1 rx_en && irq_en[5] |-> irq)
        else $error("frame end B did not request");
endmodule

bind rsis_top rsis_top_properties #(.LEN_W(LEN_W)) rsis_top_properties_inst (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .rx_en(rx_en), .eof_len(eof_len), .irq_en(irq_en), .ev_a(ev_a),
    .ev_b(ev_b), .eof_pulse(eof_pulse), .irq(irq));

// File: tb/rsis_top_test.sv
// Self-checking bench for the receive status block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
module rsis_top_test;
    logic                  core_clk;
    logic                  rstn;
    logic                  rx_en;
    logic [3:0]            eof_len;
    logic [7:0]            irq_en;
    rsis_pkg::rsis_rx_ev_t ev_a;
    rsis_pkg::rsis_rx_ev_t ev_b;
    logic [5:0]            reg_addr;
    logic                  reg_rd;
    logic                  reg_wr;
    logic [7:0]            reg_wdata;
    logic [7:0]            reg_rdata;
    logic                  reg_hit;
    logic [1:0]            eof_pulse;
    logic                  irq;
    int                    errors = 0;
    int                    samples_checked = 0;
    logic [7:0]            d;
    logic                  h;
    rsis_top rsis_top_inst (.core_clk(core_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .rx_en(rx_en), .eof_len(eof_len), .irq_en(irq_en), .ev_a(ev_a),
        .ev_b(ev_b), .eof_pulse(eof_pulse), .irq(irq));
    rsis_host rsis_host_inst (.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One-cycle event pulse: {load, all_valid, bit_tick, bit_valid}
    task automatic ev(input logic [3:0] a, input logic [3:0] b);
        @(negedge core_clk);
        ev_a = a;
        ev_b = b;
    endtask
    task automatic st(input logic [7:0] exp);
        rsis_host_inst.rd(6'h08, d, h);
        chk(d, exp);
    endtask
    task automatic t_regs();
        st(8'h00);
        chk({7'h00, h}, 8'h01);
        rsis_host_inst.wr(6'h08, 8'hff);
        st(8'h00);
        rsis_host_inst.rd(6'h0a, d, h);
        chk(d, 8'h00);
        chk({7'h00, h}, 8'h00);
    endtask
    task automatic t_full();
        irq_en = 8'hff;
        ev(4'hc, 4'h8);
        ev(4'h0, 4'h0);
        chk({7'h00, irq}, 8'h01);
        st(8'h19);
        st(8'h08);
        chk({7'h00, irq}, 8'h00);
    endtask
    task automatic t_flow();
        irq_en = 8'h00;
        rsis_host_inst.rd(6'h09, d, h);
        rsis_host_inst.rd(6'h0b, d, h);
        ev(4'h8, 4'h0);
        ev(4'h8, 4'h0);
        ev(4'h0, 4'h0);
        st(8'h05);
        st(8'h00);
        rsis_host_inst.rd(6'h0b, d, h);
        st(8'h40);
        // A is still unread, so this load overflows; the data read
        // then clears full while flow waits for the status read
        ev(4'h8, 4'h0);
        ev(4'h0, 4'h0);
        rsis_host_inst.rd(6'h09, d, h);
        st(8'h04);
    endtask
    task automatic t_eof();
        irq_en = 8'h22;
        ev(4'h3, 4'h0);
        ev(4'h2, 4'h0);
        #1 chk({6'h00, eof_pulse}, 8'h01);
        ev(4'h0, 4'h0);
        chk({7'h00, irq}, 8'h01);
        st(8'h02);
        chk({7'h00, irq}, 8'h00);
        eof_len = 4'h2;
        ev(4'h0, 4'h3);
        ev(4'h0, 4'h2);
        ev(4'h0, 4'h2);
        #1 chk({6'h00, eof_pulse}, 8'h00);
        ev(4'h0, 4'h0);
        chk({7'h00, irq}, 8'h00);
        ev(4'h0, 4'h2);
        #1 chk({6'h00, eof_pulse}, 8'h02);
        ev(4'h0, 4'h0);
        chk({7'h00, irq}, 8'h01);
        st(8'h20);
    endtask
    task automatic t_rxoff();
        irq_en = 8'hff;
        ev(4'h8, 4'h8);
        ev(4'h0, 4'h0);
        chk({7'h00, irq}, 8'h01);
        // Receive drops in the very cycle of the read, state still set
        fork
            st(8'h00);
            begin
                @(negedge core_clk);
                rx_en = 1'b0;
                #1 chk({7'h00, irq}, 8'h00);
            end
        join
        st(8'h00);
        chk({7'h00, irq}, 8'h00);
        rx_en = 1'b1;
        st(8'h00);
    endtask
    task automatic end_of_test();
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Whole run is about 75 cycles; this leaves wide margin
    initial
    begin
        repeat (3000) @(posedge core_clk);
        errors++;
        end_of_test();
    end
    initial
    begin
        rstn = 1'b0;
        rx_en = 1'b1;
        eof_len = 4'h0;
        irq_en = 8'h00;
        ev_a = 4'h0;
        ev_b = 4'h0;
        repeat (20) @(negedge core_clk);
        rstn = 1'b1;
        t_regs();
        t_full();
        t_flow();
        t_eof();
        t_rxoff();
        end_of_test();
    end
endmodule
